//--- design/mrr_bank.v
// mmio register bank: reset values per reset kind and configuration write locks
//
// Behaviour
// RULE_01 - capability and table-offset registers are constant
// RULE_02 - config, control, status, cause, queues, permissions clear
// RULE_03 - group token field loads total tokens
// RULE_04 - command words zeroed except on software reset
// RULE_05 - perfmon filters reset to ffff, others zero
// RULE_06 - msix entries reset only on power-on
// RULE_07 - message storage masked, default address, rest zero
// RULE_08 - general configuration locked unless device disabled
// RULE_09 - fixed configuration supplies queue and group resets
// RULE_10 - tables placed at reported offsets
// RULE_11 - capability bit 31 reports configurability
// RULE_12 - group configuration locked unless device disabled
`include "mrr_regs.vh"
module mrr_bank #(
    parameter NGRP = 4,
    parameter NWQ = 4,
    parameter NPM = 4,
    parameter NMSIX = 4,
    parameter NIMS = 4,
    parameter CONFIG_SUPPORT = 1,
    parameter [7:0] TOTAL_TOKENS = 8'h10,
    parameter [31:0] VERSION_VAL = 32'h00000100,
    parameter [31:0] ID_CAP_VAL = 32'h00000000,
    parameter [31:0] FIXED_WKQ_CFG = 32'h00000001,
    parameter [31:0] FIXED_GRP_CFG = 32'h00000001
) (
    input wire ref_clk,
    input wire rst,
    input wire [1:0] reset_kind,
    input wire [1:0] device_state,
    input wire [15:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    output reg [31:0] gen_cfg_out,
    output reg [31:0] gen_ctl_out
);
    // capability words; any value here is arbitrary apart from bit 31
    wire cfg_sup = (CONFIG_SUPPORT != 0); // RULE_11
    wire [31:0] gen_cap_val = {cfg_sup, 31'h00000000}; // RULE_11
    wire [31:0] tblofs_val = {`MRR_MST_BASE, `MRR_GRP_BASE}; // RULE_10
    wire [31:0] tblofs_hi = {`MRR_PM_BASE, `MRR_WKQ_BASE}; // RULE_10

    // device state comes from outside this clock, so two flops first
    reg [1:0] st_s1_reg;
    reg [1:0] st_s2_reg;
    always @(posedge ref_clk) begin
        st_s1_reg <= device_state;
        st_s2_reg <= st_s1_reg;
    end
    // locks follow the state two cycles late
    wire disabled = (st_s2_reg == `MRR_STATE_DISABLED);
    wire pwr = (reset_kind == `MRR_RST_POWER);
    wire sw_rst = (reset_kind == `MRR_RST_SW);

    // register selects
    wire sel_gen_cfg = (addr == `MRR_GENCFG);
    wire sel_gen_ctl = (addr == `MRR_GENCTL);
    wire sel_gen_sts = (addr == `MRR_GENSTS);
    wire sel_int_cause = (addr == `MRR_INTCAUSE);
    wire sel_cmd = (addr == `MRR_CMD);
    wire sel_cmd_sts = (addr == `MRR_CMDSTS);
    wire sel_sw_err = (addr == `MRR_SWERR);

    // flat registers
    reg [31:0] gen_cfg_reg;
    reg [31:0] gen_ctl_reg;
    reg [31:0] gen_sts_reg;
    reg [31:0] int_cause_reg;
    reg [31:0] cmd_reg;
    reg [31:0] cmd_sts_reg;
    reg [31:0] sw_err_reg;
    always @(posedge ref_clk) begin
        if (rst) begin
            gen_cfg_reg <= `MRR_ZERO; // RULE_02
            gen_ctl_reg <= `MRR_ZERO; // RULE_02
            gen_sts_reg <= `MRR_ZERO; // RULE_02
            int_cause_reg <= `MRR_ZERO; // RULE_02
            // a software reset leaves the command words alone
            if (!sw_rst) begin
                cmd_reg <= `MRR_ZERO; // RULE_04
                cmd_sts_reg <= `MRR_ZERO; // RULE_04
                sw_err_reg <= `MRR_ZERO; // RULE_04
            end
        end else if (wr) begin
            if (sel_gen_cfg && disabled) gen_cfg_reg <= wdata; // RULE_08
            if (sel_gen_ctl) gen_ctl_reg <= wdata;
            if (sel_gen_sts) gen_sts_reg <= wdata;
            // interrupt cause bits are cleared by writing ones
            if (sel_int_cause) int_cause_reg <= int_cause_reg & ~wdata;
            if (sel_cmd) cmd_reg <= wdata;
            if (sel_cmd_sts) cmd_sts_reg <= wdata;
            if (sel_sw_err) sw_err_reg <= wdata;
        end
    end

    // table windows: each entry four words at a 16-byte stride
    wire [15:0] rel_perm = addr - `MRR_PERM_BASE;
    wire [15:0] rel_grp = addr - `MRR_GRP_BASE;
    wire [15:0] rel_wkq = addr - `MRR_WKQ_BASE;
    wire [15:0] rel_pm = addr - `MRR_PM_BASE;
    wire [15:0] rel_msix = addr - `MRR_MSIX_BASE;
    wire [15:0] rel_mst = addr - `MRR_MST_BASE;
    wire [1:0] word = addr[3:2];
    // a hit needs the offset below one table span; the subtraction wraps below the base
    wire hit_perm = (rel_perm < `MRR_TBL_SPAN);
    wire hit_grp = (rel_grp < `MRR_TBL_SPAN);
    wire hit_wkq = (rel_wkq < `MRR_TBL_SPAN);
    wire hit_pm = (rel_pm < `MRR_TBL_SPAN);
    wire hit_msix = (rel_msix < `MRR_TBL_SPAN);
    wire hit_mst = (rel_mst < `MRR_TBL_SPAN);
    wire [3:0] idx_perm = rel_perm[7:4];
    wire [3:0] idx_grp = rel_grp[7:4];
    wire [3:0] idx_wkq = rel_wkq[7:4];
    wire [3:0] idx_pm = rel_pm[7:4];
    wire [3:0] idx_msix = rel_msix[7:4];
    wire [3:0] idx_mst = rel_mst[7:4];

    // group reset word: token field loaded, other fields zero when configurable; FIXED_GRP_CFG otherwise
    wire [31:0] grp_rst0 = cfg_sup ? {24'h000000, TOTAL_TOKENS} : FIXED_GRP_CFG; // RULE_03 RULE_09
    wire [31:0] wkq_rst0 = cfg_sup ? `MRR_ZERO : FIXED_WKQ_CFG; // RULE_09
    wire do_rst_all = rst;
    // msix table keeps its contents except at power-on
    wire do_rst_msix = rst & pwr; // RULE_06

    // read words per entry, zero past the configured count
    wire [31:0] perm_rd [0:`MRR_MAX_ENT-1];
    wire [31:0] grp_rd [0:`MRR_MAX_ENT-1];
    wire [31:0] wkq_rd [0:`MRR_MAX_ENT-1];
    wire [31:0] pm_rd [0:`MRR_MAX_ENT-1];
    wire [31:0] msix_rd [0:`MRR_MAX_ENT-1];
    wire [31:0] mst_rd [0:`MRR_MAX_ENT-1];
    genvar g;
    generate
        for (g = 0; g < `MRR_MAX_ENT; g = g + 1) begin : ent
            localparam [3:0] SLOT = g;
            // per-entry write enables
            wire we_perm = wr && hit_perm && (idx_perm == SLOT);
            wire we_msix = wr && hit_msix && (idx_msix == SLOT);
            wire we_grp = wr && hit_grp && (idx_grp == SLOT) && disabled && cfg_sup; // RULE_12 RULE_09
            wire we_wkq = wr && hit_wkq && (idx_wkq == SLOT);
            wire we_pm = wr && hit_pm && (idx_pm == SLOT);
            wire we_mst = wr && hit_mst && (idx_mst == SLOT);
            if (g < NMSIX) begin : p
                mrr_entry u_perm (
                    .ref_clk(ref_clk),
                    .do_reset(do_rst_all),
                    .rst_w0(`MRR_ZERO),
                    .use_rst_w0(1'b0),
                    .wr_en(we_perm),
                    .wr_word(word),
                    .wr_data(wdata),
                    .rd_word(word),
                    .rd_data(perm_rd[g])
                ); // RULE_02
                mrr_entry #(.RST3(`MRR_ONE)) u_msix (
                    .ref_clk(ref_clk),
                    .do_reset(do_rst_msix),
                    .rst_w0(`MRR_ZERO),
                    .use_rst_w0(1'b0),
                    .wr_en(we_msix),
                    .wr_word(word),
                    .wr_data(wdata),
                    .rd_word(word),
                    .rd_data(msix_rd[g])
                ); // RULE_06
            end else begin : pz
                assign perm_rd[g] = `MRR_ZERO;
                assign msix_rd[g] = `MRR_ZERO;
            end

            if (g < NGRP) begin : gr
                mrr_entry u_grp (
                    .ref_clk(ref_clk),
                    .do_reset(do_rst_all),
                    .rst_w0(grp_rst0),
                    .use_rst_w0(1'b1),
                    .wr_en(we_grp),
                    .wr_word(word),
                    .wr_data(wdata),
                    .rd_word(word),
                    .rd_data(grp_rd[g])
                ); // RULE_12 RULE_03
            end else begin : gz
                assign grp_rd[g] = `MRR_ZERO;
            end

            if (g < NWQ) begin : wkq
                mrr_entry u_wkq (
                    .ref_clk(ref_clk),
                    .do_reset(do_rst_all),
                    .rst_w0(wkq_rst0),
                    .use_rst_w0(1'b1),
                    .wr_en(we_wkq),
                    .wr_word(word),
                    .wr_data(wdata),
                    .rd_word(word),
                    .rd_data(wkq_rd[g])
                ); // RULE_02 RULE_09
            end else begin : wz
                assign wkq_rd[g] = `MRR_ZERO;
            end

            // perfmon filter word resets to 0000ffff, ones in its low half only
            if (g < NPM) begin : pm
                mrr_entry #(.RST1(`MRR_PM_FILTER_RST)) u_pm (
                    .ref_clk(ref_clk),
                    .do_reset(do_rst_all),
                    .rst_w0(`MRR_ZERO),
                    .use_rst_w0(1'b0),
                    .wr_en(we_pm),
                    .wr_word(word),
                    .wr_data(wdata),
                    .rd_word(word),
                    .rd_data(pm_rd[g])
                ); // RULE_05
            end else begin : mz
                assign pm_rd[g] = `MRR_ZERO;
            end

            // message storage comes up masked at the default address
            if (g < NIMS) begin : im
                mrr_entry #(.RST1(`MRR_MST_ADDR_RST), .RST3(`MRR_ONE)) u_mst (
                    .ref_clk(ref_clk),
                    .do_reset(do_rst_all),
                    .rst_w0(`MRR_ZERO),
                    .use_rst_w0(1'b0),
                    .wr_en(we_mst),
                    .wr_word(word),
                    .wr_data(wdata),
                    .rd_word(word),
                    .rd_data(mst_rd[g])
                ); // RULE_07
            end else begin : iz
                assign mst_rd[g] = `MRR_ZERO;
            end
        end
    endgenerate

    // read mux; unmapped addresses read zero
    reg [31:0] rd_next;
    always @* begin
        rd_next = `MRR_ZERO;
        case (addr)
            `MRR_VERSION: rd_next = VERSION_VAL; // RULE_01
            `MRR_GEN_CAP: rd_next = gen_cap_val; // RULE_01
            `MRR_WQCAP: rd_next = ID_CAP_VAL;
            `MRR_GRPCAP: rd_next = ID_CAP_VAL;
            `MRR_ENGCAP: rd_next = ID_CAP_VAL;
            `MRR_OPCAP: rd_next = ID_CAP_VAL;
            `MRR_CMDCAP: rd_next = ID_CAP_VAL;
            `MRR_PMCAP: rd_next = ID_CAP_VAL;
            `MRR_TBLOFS: rd_next = tblofs_val; // RULE_10
            `MRR_TBLOFS_HI: rd_next = tblofs_hi; // RULE_10
            `MRR_GENCFG: rd_next = gen_cfg_reg;
            `MRR_GENCTL: rd_next = gen_ctl_reg;
            `MRR_GENSTS: rd_next = gen_sts_reg;
            `MRR_INTCAUSE: rd_next = int_cause_reg;
            `MRR_CMD: rd_next = cmd_reg;
            `MRR_CMDSTS: rd_next = cmd_sts_reg;
            `MRR_SWERR: rd_next = sw_err_reg;
            default: begin
                if (hit_perm) begin
                    rd_next = perm_rd[idx_perm];
                end else if (hit_grp) begin
                    rd_next = grp_rd[idx_grp];
                end else if (hit_wkq) begin
                    rd_next = wkq_rd[idx_wkq];
                end else if (hit_pm) begin
                    rd_next = pm_rd[idx_pm];
                end else if (hit_msix) begin
                    rd_next = msix_rd[idx_msix];
                end else if (hit_mst) begin
                    rd_next = mst_rd[idx_mst];
                end
            end
        endcase
    end

    // read data stands one cycle only, zero otherwise
    always @(posedge ref_clk) begin
        if (rst) begin
            rdata <= `MRR_ZERO;
        end else begin
            rdata <= rd ? rd_next : `MRR_ZERO;
        end
    end

    // copies lag the registers by a cycle so every port comes from a flop
    always @(posedge ref_clk) begin
        if (rst) begin
            gen_cfg_out <= `MRR_ZERO;
            gen_ctl_out <= `MRR_ZERO;
        end else begin
            gen_cfg_out <= gen_cfg_reg;
            gen_ctl_out <= gen_ctl_reg;
        end
    end
endmodule // mrr_bank

//--- design/mrr_regs.vh
// register offsets, reset values and field positions for the mmio reset-value bank
`ifndef MRR_REGS_VH
`define MRR_REGS_VH
`define MRR_AW 16
`define MRR_DW 32
// capability and table-offset words
`define MRR_VERSION 16'h0000
`define MRR_GEN_CAP 16'h0010
`define MRR_WQCAP 16'h0020
`define MRR_GRPCAP 16'h0030
`define MRR_ENGCAP 16'h0038
`define MRR_OPCAP 16'h0048
`define MRR_TBLOFS 16'h0060
`define MRR_TBLOFS_HI 16'h0064
`define MRR_CMDCAP 16'h00b0
`define MRR_PMCAP 16'h00f0
// configuration, control, status words
`define MRR_GENCFG 16'h0080
`define MRR_GENCTL 16'h0088
`define MRR_GENSTS 16'h0090
`define MRR_INTCAUSE 16'h0098
`define MRR_CMD 16'h00a0
`define MRR_CMDSTS 16'h00a8
`define MRR_SWERR 16'h00c8
// table bases
`define MRR_PERM_BASE 16'h0400
`define MRR_GRP_BASE 16'h0600
`define MRR_WKQ_BASE 16'h0800
`define MRR_PM_BASE 16'h2000
`define MRR_PBA_BASE 16'h5000
`define MRR_MSIX_BASE 16'h4000
`define MRR_MST_BASE 16'h8000
// entry stride and table span (bytes), entry count
`define MRR_STRIDE 16'h0010
`define MRR_TBL_SPAN 16'h0100
`define MRR_MAX_ENT 16
// field positions and reset values
`define MRR_CFG_SUPPORT_BIT 31
`define MRR_GRP_TOKEN_LSB 0
`define MRR_GRP_TOKEN_W 8
`define MRR_PM_FILTER_RST 32'h0000ffff
`define MRR_MST_ADDR_RST 32'hfee00000
`define MRR_ZERO 32'h00000000
`define MRR_ONE 32'h00000001
`define MRR_STATE_DISABLED 2'h0
// reset-kind codes
`define MRR_RST_POWER 2'h0
`define MRR_RST_WARM 2'h1
`define MRR_RST_FLR 2'h2
`define MRR_RST_SW 2'h3
`endif

//--- design/mrr_entry.v
// one table entry of four words with its own reset value and write enable
module mrr_entry #(
    parameter [31:0] RST0 = 32'h00000000,
    parameter [31:0] RST1 = 32'h00000000,
    parameter [31:0] RST2 = 32'h00000000,
    parameter [31:0] RST3 = 32'h00000000
) (
    input wire ref_clk,
    input wire do_reset,
    input wire [31:0] rst_w0,
    input wire use_rst_w0,
    input wire wr_en,
    input wire [1:0] wr_word,
    input wire [31:0] wr_data,
    input wire [1:0] rd_word,
    output wire [31:0] rd_data
);
    reg [31:0] word_reg [0:3];
    always @(posedge ref_clk) begin
        if (do_reset) begin
            word_reg[0] <= use_rst_w0 ? rst_w0 : RST0;
            word_reg[1] <= RST1;
            word_reg[2] <= RST2;
            word_reg[3] <= RST3;
        end else if (wr_en) begin
            word_reg[wr_word] <= wr_data;
        end
    end
    assign rd_data = word_reg[rd_word];
endmodule // mrr_entry

//--- verif/mrr_bank_assertions.sv
// concurrent checks on the ports of the mmio reset-value bank
`include "mrr_regs.vh"
module mrr_bank_assertions #(
    parameter CONFIG_SUPPORT = 1,
    parameter [31:0] VERSION_VAL = 32'h00000100
) (
    input wire ref_clk,
    input wire rst,
    input wire [1:0] reset_kind,
    input wire [1:0] device_state,
    input wire [15:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    input wire [31:0] gen_cfg_out,
    input wire [31:0] gen_ctl_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    rdata_idle_a: assert property (!rd |=> rdata == 32'h00000000)
        else $error("read data not zero after an idle cycle");
    version_read_a: assert property (rd && addr == `MRR_VERSION |=> rdata == VERSION_VAL)
        else $error("version word wrong");
    gen_cap_bit_a: assert property (rd && addr == `MRR_GEN_CAP |=> rdata[31] == (CONFIG_SUPPORT != 0))
        else $error("configurability bit wrong");
    offsets_read_a: assert property (rd && addr == `MRR_TBLOFS |=> rdata == {`MRR_MST_BASE, `MRR_GRP_BASE})
        else $error("table offset word wrong");
    cfg_reset_a: assert property ($past(rst) |-> gen_cfg_out == 32'h00000000 && gen_ctl_out == 32'h00000000)
        else $error("config or control not cleared by reset");
    // four cycles cover the two-flop state synchroniser plus the output lag
    cfg_lock_a: assert property ((device_state != 2'h0 && !rst) [*4] |=> $stable(gen_cfg_out))
        else $error("general config changed while not disabled");
    cfg_write_a: assert property ((device_state == 2'h0 && !rst) [*4] ##0 (wr && addr == `MRR_GENCFG)
        |=> ##1 gen_cfg_out == $past(wdata, 2))
        else $error("general config write lost while disabled");
    cfg_read_a: assert property (rd && addr == `MRR_GENCFG |=> rdata == $past(gen_cfg_out))
        else $error("general config read differs from its copy");
endmodule // mrr_bank_assertions
bind mrr_bank mrr_bank_assertions #(.CONFIG_SUPPORT(CONFIG_SUPPORT), .VERSION_VAL(VERSION_VAL)) u_chk (.*);

//--- verif/mrr_bank_tb.sv
// self-checking bench for the mmio reset-value bank
`include "mrr_regs.vh"
module mrr_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] reset_kind = 2'h0;
    logic [1:0] device_state = 2'h0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    wire [31:0] rdata;
    wire [31:0] rdata_fix;
    logic [31:0] r, rf, v;
    int errors = 0;
    int total_checks = 0;
    logic [15:0] caps [7] = '{`MRR_VERSION, `MRR_WQCAP, `MRR_GRPCAP, `MRR_ENGCAP, `MRR_OPCAP, `MRR_CMDCAP, `MRR_PMCAP};
    logic [15:0] regs [13] = '{`MRR_GENCFG, `MRR_GENCTL, `MRR_GENSTS, `MRR_INTCAUSE, `MRR_CMD, `MRR_WKQ_BASE,
        `MRR_PERM_BASE, `MRR_GRP_BASE, `MRR_PM_BASE + 16'h0004, `MRR_MSIX_BASE, `MRR_MSIX_BASE + 16'h000c,
        `MRR_MST_BASE + 16'h0004, `MRR_MST_BASE + 16'h000c};
    always #10 ref_clk = ~ref_clk;
    mrr_bank dut (.*, .gen_cfg_out(), .gen_ctl_out());
    // second bank with fixed configuration, same stimulus
    mrr_bank #(.CONFIG_SUPPORT(0)) dut_fixed (.*, .rdata(rdata_fix), .gen_cfg_out(), .gen_ctl_out());
    function automatic logic [31:0] exp_val(input logic [15:0] a, input int k, input logic [31:0] w, input bit fx);
        if (fx && (a == `MRR_GRP_BASE || a == `MRR_WKQ_BASE)) return 32'h00000001;
        case (a)
            `MRR_CMD: return (k == 3) ? w : 32'h00000000;
            `MRR_MSIX_BASE: return (k == 0) ? 32'h00000000 : w;
            `MRR_MSIX_BASE + 16'h000c: return (k == 0) ? 32'h00000001 : 32'h00000000;
            `MRR_GRP_BASE: return 32'h00000010;
            `MRR_PM_BASE + 16'h0004: return `MRR_PM_FILTER_RST;
            `MRR_MST_BASE + 16'h0004: return `MRR_MST_ADDR_RST;
            `MRR_MST_BASE + 16'h000c: return `MRR_ONE;
            default: return 32'h00000000;
        endcase
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_word(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_word(input logic [15:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        r = rdata;
        rf = rdata_fix;
    endtask
    task automatic do_reset(input logic [1:0] k);
        @(posedge ref_clk);
        reset_kind <= k;
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // the whole sequence needs about 360 cycles; forty times that is a hang
    initial begin
        #300000;
        errors++;
        stop_test();
    end
    initial begin
        void'($urandom(3));
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (caps[i]) begin
            wr_word(caps[i], $urandom);
            rd_word(caps[i]);
            chk("capability", r, (i == 0) ? 32'h00000100 : 32'h00000000);
        end
        wr_word(`MRR_GEN_CAP, $urandom);
        rd_word(`MRR_GEN_CAP);
        chk("config support", {30'h0, r[31], rf[31]}, 32'h00000002);
        rd_word(`MRR_TBLOFS);
        chk("offsets low", r, {`MRR_MST_BASE, `MRR_GRP_BASE});
        rd_word(`MRR_TBLOFS + 16'h0004);
        chk("offsets high", r, {`MRR_PM_BASE, `MRR_WKQ_BASE});
        $display("test capabilities done");
        for (int k = 0; k < 4; k++) begin
            v = $urandom;
            // mask word written clear so a kept value is told from a reset one
            foreach (regs[i]) wr_word(regs[i], (i == 10) ? 32'h00000000 : v);
            wr_word(16'h0040, v);
            do_reset(k[1:0]);
            foreach (regs[i]) begin
                rd_word(regs[i]);
                chk("after reset", r, exp_val(regs[i], k, v, 1'b0));
                chk("after reset fixed", rf, exp_val(regs[i], k, v, 1'b1));
            end
            $display("test reset kind %0d done", k);
        end
        for (int s = 1; s < 4; s++) begin
            @(posedge ref_clk);
            device_state <= s[1:0];
            repeat (3) @(posedge ref_clk);
            v = $urandom;
            wr_word(`MRR_GENCFG, v);
            wr_word(`MRR_GRP_BASE, v);
            rd_word(`MRR_GENCFG);
            chk("config locked", r, 32'h00000000);
            rd_word(`MRR_GRP_BASE);
            chk("group locked", r, 32'h00000010);
            @(posedge ref_clk);
            device_state <= 2'h0;
            repeat (3) @(posedge ref_clk);
            wr_word(`MRR_GENCFG, v);
            wr_word(`MRR_GRP_BASE, v);
            rd_word(`MRR_GENCFG);
            chk("config open", r, v);
            rd_word(`MRR_GRP_BASE);
            chk("group open", r, v);
            chk("group fixed", rf, 32'h00000001);
            do_reset(2'h3);
        end
        $display("test write locks done");
        stop_test();
    end
endmodule // mrr_bank_tb
